// [verif/host_port_model.sv]
// Host model issuing single-byte register writes and reads.
// Assumes the block samples strobes on the rising clock edge.
`timescale 1ns/1ps
module host_port_model (
	// Clock
	input  wire logic       mclk_i,
	// Register port
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o,
	input  wire logic [7:0] reg_rdata_i
);
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
	end

	// Released lines show the inverse so stale values cannot pass.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge mclk_i);
		reg_wr_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk_i);
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(negedge mclk_i);
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		d = reg_rdata_i;
	endtask
endmodule

// [verif/multifunction_pin_select_properties.sv]
// Concurrent checks on the ports of the pin selection block.
// Assumes one clock domain and single-cycle register strobes.
`timescale 1ns/1ps
module pin_select_checker
	import pin_select_pkg::*;
(
	// Clock, reset and register port
	input wire logic       mclk_i,
	input wire logic       rst_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	// Sources
	input wire logic       shared_bitbang_level_i,
	input wire logic       pdm_clock_i,
	input wire logic       general_clock_output_i,
	input wire logic       interrupt_line_one_i,
	input wire logic       interrupt_line_two_i,
	input wire logic       interrupt_line_three_i,
	input wire logic       interrupt_line_four_i,
	input wire logic       port_one_word_clock_out_i,
	input wire logic       port_one_bit_clock_out_i,
	input wire logic       port_one_data_out_i,
	input wire logic       port_two_bit_clock_out_i,
	input wire logic       port_two_data_out_i,
	input wire logic       main_port_word_clock_out_i,
	input wire logic       main_port_bit_clock_out_i,
	input wire logic       main_port_data_out_i,
	// Pins
	input wire logic       audio_data_in2_pin_i,
	input wire logic       audio_data_in2_pin_o,
	input wire logic       audio_data_in2_pin_oe_o,
	input wire logic       audio_data_in2_pin_ie_o,
	input wire logic       audio_data_in2_fwd_o,
	input wire logic       link_clock_pin_o,
	input wire logic       link_clock_pin_oe_o,
	input wire logic       link_clock_pin_ie_o,
	input wire logic       link_clock_fwd_o,
	input wire logic       link_data_pin_o,
	input wire logic       link_data_pin_oe_o
);
	// --------------------------------------------------------------
	// Shadow of the pin registers
	// --------------------------------------------------------------
	logic [7:0]  shadow_r [NUM_PINS];
	logic [13:0] src_v;
	wire  logic  hit = reg_addr_i inside {[OFF_DATA_IN2:OFF_LINK_DATA]};
	wire  logic [4:0] sel0 = shadow_r[0][4:0];
	wire  logic [4:0] sel1 = shadow_r[1][4:0];
	wire  logic [4:0] sel2 = shadow_r[2][4:0];
	wire  logic  lvl2 = shadow_r[2][LEVEL_BIT];
	wire  logic [7:0] rd_want = hit ? shadow_r[reg_addr_i[1:0]]
		: RDATA_UNMAPPED;
	logic        pick_want;

	assign src_v = {main_port_data_out_i, main_port_bit_clock_out_i,
		main_port_word_clock_out_i, port_two_data_out_i,
		port_two_bit_clock_out_i, port_one_data_out_i,
		port_one_bit_clock_out_i, port_one_word_clock_out_i,
		interrupt_line_four_i, interrupt_line_three_i,
		interrupt_line_two_i, interrupt_line_one_i,
		general_clock_output_i, pdm_clock_i};

	function automatic logic pick(input logic [4:0] s,
		input logic [13:0] v);
		case (s)
			5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a: return v[s-5'h05];
			5'h0c, 5'h0d: return v[s-5'h06];
			5'h10: return v[8];
			5'h12: return v[9];
			5'h15: return v[10];
			5'h1b, 5'h1c, 5'h1d: return v[s-5'h10];
			default: return 1'b0;
		endcase
	endfunction

	assign pick_want = pick(sel0, src_v);

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			shadow_r <= '{default: PIN_REG_RESET};
		else if (reg_wr_i && hit)
			shadow_r[reg_addr_i[1:0]] <= reg_wdata_i;
	end

	// --------------------------------------------------------------
	// Properties
	// --------------------------------------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	AST_DISABLED_QUIET: assert property (sel0 == 5'h00 |=>
		!audio_data_in2_pin_oe_o && !audio_data_in2_pin_ie_o
		&& !audio_data_in2_fwd_o) else $error("disabled pin active");
	AST_INPUT_FWD: assert property (sel0 == 5'h01 |=>
		audio_data_in2_pin_ie_o && !audio_data_in2_pin_oe_o
		&& audio_data_in2_fwd_o == $past(audio_data_in2_pin_i))
		else $error("input pin not forwarded");
	AST_FWD_GATED: assert property (sel1 != 5'h01 |=>
		!link_clock_fwd_o && !link_clock_pin_ie_o)
		else $error("forward active off input mode");
	AST_LEVEL_OUT: assert property (sel2 == 5'h03 |=>
		link_data_pin_oe_o && link_data_pin_o == $past(lvl2))
		else $error("level output wrong");
	AST_BITBANG_OUT: assert property (sel1 == 5'h04 |=>
		link_clock_pin_oe_o
		&& link_clock_pin_o == $past(shared_bitbang_level_i))
		else $error("shared level output wrong");
	AST_SOURCE_OUT: assert property (
		sel0 inside {[5:10], 12, 13, 16, 18, 21, [27:29]} |=>
		audio_data_in2_pin_oe_o && audio_data_in2_pin_o == $past(pick_want))
		else $error("source output wrong");
	AST_RESERVED_QUIET: assert property (
		sel0 inside {2, 11, [14:15], [19:20], [22:26], [30:31]} |=>
		!audio_data_in2_pin_oe_o && !audio_data_in2_pin_o
		&& !audio_data_in2_pin_ie_o && !audio_data_in2_fwd_o)
		else $error("reserved code drives pin");
	AST_READ_BACK: assert property (reg_rd_i |=>
		reg_rdata_o == $past(rd_want)) else $error("read data wrong");

	cover property (sel0 == 5'h01);
	cover property (sel2 == 5'h03);
	cover property (reg_rd_i && !hit);
endmodule

bind multifunction_pin_select pin_select_checker u_checker (
	.mclk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
	.reg_rdata_o, .shared_bitbang_level_i, .pdm_clock_i,
	.general_clock_output_i, .interrupt_line_one_i, .interrupt_line_two_i,
	.interrupt_line_three_i, .interrupt_line_four_i,
	.port_one_word_clock_out_i, .port_one_bit_clock_out_i,
	.port_one_data_out_i, .port_two_bit_clock_out_i, .port_two_data_out_i,
	.main_port_word_clock_out_i, .main_port_bit_clock_out_i,
	.main_port_data_out_i, .audio_data_in2_pin_i, .audio_data_in2_pin_o,
	.audio_data_in2_pin_oe_o, .audio_data_in2_pin_ie_o,
	.audio_data_in2_fwd_o, .link_clock_pin_o, .link_clock_pin_oe_o,
	.link_clock_pin_ie_o, .link_clock_fwd_o, .link_data_pin_o,
	.link_data_pin_oe_o);

// [verif/multifunction_pin_select_tb.sv]
// Self-checking bench for the multifunction pin selection block.
// Assumes the host model on the register port; sources come from here.
`timescale 1ns/1ps
module multifunction_pin_select_tb
	import pin_select_pkg::*;
;
	logic        mclk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        reg_wr, reg_rd, bb = 1'b0;
	logic [7:0]  reg_addr, wdata, rdata;
	logic [13:0] src = 14'h0000;
	logic [2:0]  pin_in = 3'h0;
	logic [2:0]  pin_o, pin_oe, pin_ie, fwd;
	int          bad_count = 0;
	int          n_compared = 0;

	always #5 mclk_i = ~mclk_i;

	host_port_model u_host (.mclk_i(mclk_i), .reg_wr_o(reg_wr),
		.reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(wdata),
		.reg_rdata_i(rdata));

	multifunction_pin_select u_dut (.mclk_i(mclk_i), .rst_i(rst_i),
		.reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.shared_bitbang_level_i(bb), .pdm_clock_i(src[0]),
		.general_clock_output_i(src[1]), .interrupt_line_one_i(src[2]),
		.interrupt_line_two_i(src[3]), .interrupt_line_three_i(src[4]),
		.interrupt_line_four_i(src[5]), .port_one_word_clock_out_i(src[6]),
		.port_one_bit_clock_out_i(src[7]), .port_one_data_out_i(src[8]),
		.port_two_bit_clock_out_i(src[9]), .port_two_data_out_i(src[10]),
		.main_port_word_clock_out_i(src[11]),
		.main_port_bit_clock_out_i(src[12]),
		.main_port_data_out_i(src[13]),
		.audio_data_in2_pin_i(pin_in[0]), .audio_data_in2_pin_o(pin_o[0]),
		.audio_data_in2_pin_oe_o(pin_oe[0]),
		.audio_data_in2_pin_ie_o(pin_ie[0]), .audio_data_in2_fwd_o(fwd[0]),
		.link_clock_pin_i(pin_in[1]), .link_clock_pin_o(pin_o[1]),
		.link_clock_pin_oe_o(pin_oe[1]), .link_clock_pin_ie_o(pin_ie[1]),
		.link_clock_fwd_o(fwd[1]), .link_data_pin_i(pin_in[2]),
		.link_data_pin_o(pin_o[2]), .link_data_pin_oe_o(pin_oe[2]),
		.link_data_pin_ie_o(pin_ie[2]), .link_data_fwd_o(fwd[2]));

	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	// Pin state packed as oe, ie, forward, output.
	task automatic pin_chk(input int p, input logic [7:0] e);
		repeat (2) @(negedge mclk_i);
		chk($sformatf("pin%0d", p), e,
			{4'h0, pin_oe[p], pin_ie[p], fwd[p], pin_o[p]});
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		u_host.rd(a, v);
		chk($sformatf("reg %h", a), e, v);
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_reset();
		for (int p = 0; p < 3; p++) begin
			rd_chk(OFF_DATA_IN2 + 8'(p), PIN_REG_RESET);
			pin_chk(p, 8'h00);
		end
		rd_chk(8'h47, RDATA_UNMAPPED);
	endtask

	task automatic t_store();
		src = 14'h3fff;
		bb = 1'b1;
		u_host.wr(8'h43, 8'hff);
		u_host.wr(OFF_DATA_IN2, 8'hef);
		u_host.wr(OFF_LINK_CLOCK, 8'ha2);
		rd_chk(OFF_DATA_IN2, 8'hef);
		rd_chk(OFF_LINK_CLOCK, 8'ha2);
		rd_chk(8'h43, RDATA_UNMAPPED);
		pin_chk(1, 8'h00);
	endtask

	task automatic t_level();
		for (int lv = 0; lv < 2; lv++) begin
			u_host.wr(OFF_LINK_DATA, lv ? 8'hc3 : 8'ha3);
			pin_chk(2, 8'h08 | 8'(lv));
		end
		u_host.wr(OFF_LINK_CLOCK, 8'h44);
		bb = 1'b0;
		pin_chk(1, 8'h08);
		bb = 1'b1;
		pin_chk(1, 8'h09);
	endtask

	// Each pin in turn, so a pad input wired to the wrong cell shows up.
	task automatic t_input();
		for (int p = 0; p < 3; p++) begin
			u_host.wr(OFF_DATA_IN2 + 8'(p), 8'h41);
			pin_in[p] = 1'b1;
			pin_chk(p, 8'h06);
			pin_in[p] = 1'b0;
			pin_chk(p, 8'h04);
		end
	endtask

	// Codes in source index order, so entry i selects source bit i.
	task automatic t_map();
		logic [4:0] c [14] = '{5, 6, 7, 8, 9, 10, 12, 13, 16, 18, 21,
			27, 28, 29};
		for (int p = 0; p < 3; p++) begin
			for (int i = 0; i < 14; i++) begin
				u_host.wr(OFF_DATA_IN2 + 8'(p), {3'h0, c[i]});
				src = 14'h0001 << i;
				pin_chk(p, 8'h09);
				src = ~src;
				pin_chk(p, 8'h08);
			end
			// Code 17 differs by pin: port two's bit clock on the link
			// clock pin, port one's word clock on the other two.
			u_host.wr(OFF_DATA_IN2 + 8'(p), 8'h11);
			src = 14'h0001 << ((p == PIN_LINK_CLOCK) ? SRC_P2_BCLK
				: SRC_P1_WCLK);
			pin_chk(p, 8'h09);
			src = ~src;
			pin_chk(p, 8'h08);
		end
	endtask

	task automatic t_reserved();
		logic [4:0] c [14] = '{0, 2, 11, 14, 15, 19, 20, 22, 23, 24, 25,
			26, 30, 31};
		src = 14'h3fff;
		pin_in = 3'h7;
		for (int i = 0; i < 14; i++) begin
			u_host.wr(OFF_LINK_DATA, {3'h2, c[i]});
			pin_chk(2, 8'h00);
		end
	endtask

	task automatic end_sim();
		if (bad_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (6) @(negedge mclk_i);
		rst_i = 1'b0;
		t_reset();
		t_store();
		t_level();
		t_input();
		t_map();
		t_reserved();
		end_sim();
	end

	// The whole run needs well under a thousand cycles.
	initial begin
		#100000;
		bad_count++;
		end_sim();
	end
endmodule

// [verilog/multifunction_pin_select.sv]
// Top of the multifunction pin selection block for three shared pins.
// Assumes the control port delivers synchronous byte accesses.
//
// Overview of operation
// R1: Bits 4..0 select function; zero disables pin buffers; reset value zero.
// R2: Code 1 makes pin an input forwarded to the input multiplexer.
// R3: Code 3 drives pin from its own level bit 6.
// R4: Code 4 drives pin from the shared bit-bang level.
// R5: Code 5 outputs the PDM data input clock.
// R6: Code 6 outputs the general clock output.
// R7: Codes 7 to 10 output interrupt lines one to four.
// R8: Codes 12 and 13 output port one word and bit clock.
// R9: Codes 16,18,21,27,28,29 output audio serial port signals.
// R10: Link data pin register uses the same level-bit layout.
// R11: Reserved selector codes leave the pin undriven, as disabled.
// R12: Reserved bits 7 and 5 store and read back, no effect.
`timescale 1ns/1ps
module multifunction_pin_select
	import pin_select_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk_i,
	input  wire logic              rst_i,
	// Register port
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [REG_W-1:0]  reg_wdata_i,
	output logic      [REG_W-1:0]  reg_rdata_o,
	// Internal output sources
	input  wire logic              shared_bitbang_level_i,
	input  wire logic              pdm_clock_i,
	input  wire logic              general_clock_output_i,
	input  wire logic              interrupt_line_one_i,
	input  wire logic              interrupt_line_two_i,
	input  wire logic              interrupt_line_three_i,
	input  wire logic              interrupt_line_four_i,
	input  wire logic              port_one_word_clock_out_i,
	input  wire logic              port_one_bit_clock_out_i,
	input  wire logic              port_one_data_out_i,
	input  wire logic              port_two_bit_clock_out_i,
	input  wire logic              port_two_data_out_i,
	input  wire logic              main_port_word_clock_out_i,
	input  wire logic              main_port_bit_clock_out_i,
	input  wire logic              main_port_data_out_i,
	// Audio data input 2 pin
	input  wire logic              audio_data_in2_pin_i,
	output logic                   audio_data_in2_pin_o,
	output logic                   audio_data_in2_pin_oe_o,
	output logic                   audio_data_in2_pin_ie_o,
	output logic                   audio_data_in2_fwd_o,
	// Link clock pin
	input  wire logic              link_clock_pin_i,
	output logic                   link_clock_pin_o,
	output logic                   link_clock_pin_oe_o,
	output logic                   link_clock_pin_ie_o,
	output logic                   link_clock_fwd_o,
	// Link data pin
	input  wire logic              link_data_pin_i,
	output logic                   link_data_pin_o,
	output logic                   link_data_pin_oe_o,
	output logic                   link_data_pin_ie_o,
	output logic                   link_data_fwd_o
);

	// --------------------------------------------------------------
	// Address decode
	// --------------------------------------------------------------
	wire logic [NUM_PINS-1:0]       addr_hit;
	wire logic [NUM_PINS-1:0]       wr_hit;
	wire logic [NUM_PINS*REG_W-1:0] cfg;
	wire logic [SRC_COUNT-1:0]      src;
	wire logic [NUM_PINS-1:0]       pad_in;
	wire logic [NUM_PINS-1:0]       pad_out;
	wire logic [NUM_PINS-1:0]       pad_oe;
	wire logic [NUM_PINS-1:0]       pad_ie;
	wire logic [NUM_PINS-1:0]       fwd;

	assign addr_hit[PIN_DATA_IN2]   = (reg_addr_i == OFF_DATA_IN2);
	assign addr_hit[PIN_LINK_CLOCK] = (reg_addr_i == OFF_LINK_CLOCK);
	assign addr_hit[PIN_LINK_DATA]  = (reg_addr_i == OFF_LINK_DATA);
	assign wr_hit = reg_wr_i ? addr_hit : '0;

	pin_config_regs u_regs (
		.mclk_i   (mclk_i),
		.rst_i    (rst_i),
		.wr_hit_i (wr_hit),
		.wdata_i  (reg_wdata_i),
		.rd_i     (reg_rd_i),
		.rd_hit_i (addr_hit),
		.cfg_o    (cfg),
		.rdata_o  (reg_rdata_o)
	);

	// --------------------------------------------------------------
	// Source vector and pad vectors
	// --------------------------------------------------------------
	assign src[SRC_PDM_CLK]  = pdm_clock_i;
	assign src[SRC_CLK_OUT]  = general_clock_output_i;
	assign src[SRC_IRQ_ONE]  = interrupt_line_one_i;
	assign src[SRC_IRQ_TWO]  = interrupt_line_two_i;
	assign src[SRC_IRQ_THR]  = interrupt_line_three_i;
	assign src[SRC_IRQ_FOUR] = interrupt_line_four_i;
	assign src[SRC_P1_WCLK]  = port_one_word_clock_out_i;
	assign src[SRC_P1_BCLK]  = port_one_bit_clock_out_i;
	assign src[SRC_P1_DOUT]  = port_one_data_out_i;
	assign src[SRC_P2_BCLK]  = port_two_bit_clock_out_i;
	assign src[SRC_P2_DOUT]  = port_two_data_out_i;
	assign src[SRC_M_WCLK]   = main_port_word_clock_out_i;
	assign src[SRC_M_BCLK]   = main_port_bit_clock_out_i;
	assign src[SRC_M_DOUT]   = main_port_data_out_i;

	assign pad_in[PIN_DATA_IN2]   = audio_data_in2_pin_i;
	assign pad_in[PIN_LINK_CLOCK] = link_clock_pin_i;
	assign pad_in[PIN_LINK_DATA]  = link_data_pin_i;

	// --------------------------------------------------------------
	// Per-pin function cells
	// --------------------------------------------------------------
	// Code 17 differs by pin: the link clock pin carries port two's
	// bit clock there, the other two carry port one's word clock.
	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++) begin : g_pin
			pin_function_cell #(
				.ALT_17_SRC ((g == PIN_LINK_CLOCK) ?
					SRC_P2_BCLK : SRC_P1_WCLK)
			) u_cell (
				.mclk_i    (mclk_i),
				.rst_i     (rst_i),
				.sel_i     (cfg[g*REG_W+SEL_LSB +: SEL_MSB-SEL_LSB+1]), // R1
				.level_i   (cfg[g*REG_W+LEVEL_BIT]), // R3 R10
				.bitbang_i (shared_bitbang_level_i), // R4
				.src_i     (src),
				.pad_i     (pad_in[g]),
				.pad_o     (pad_out[g]),
				.pad_oe_o  (pad_oe[g]),
				.pad_ie_o  (pad_ie[g]),
				.fwd_o     (fwd[g])
			);
		end
	endgenerate

	// --------------------------------------------------------------
	// Pin outputs, each a cell flip-flop
	// --------------------------------------------------------------
	assign audio_data_in2_pin_o    = pad_out[PIN_DATA_IN2];
	assign audio_data_in2_pin_oe_o = pad_oe[PIN_DATA_IN2];
	assign audio_data_in2_pin_ie_o = pad_ie[PIN_DATA_IN2];
	assign audio_data_in2_fwd_o    = fwd[PIN_DATA_IN2];
	assign link_clock_pin_o        = pad_out[PIN_LINK_CLOCK];
	assign link_clock_pin_oe_o     = pad_oe[PIN_LINK_CLOCK];
	assign link_clock_pin_ie_o     = pad_ie[PIN_LINK_CLOCK];
	assign link_clock_fwd_o        = fwd[PIN_LINK_CLOCK];
	assign link_data_pin_o         = pad_out[PIN_LINK_DATA];
	assign link_data_pin_oe_o      = pad_oe[PIN_LINK_DATA];
	assign link_data_pin_ie_o      = pad_ie[PIN_LINK_DATA];
	assign link_data_fwd_o         = fwd[PIN_LINK_DATA];

endmodule

// [verilog/pin_config_regs.sv]
// Three pin function registers with a registered read port.
// Assumes write and read strobes are single-cycle and synchronous.
`timescale 1ns/1ps
module pin_config_regs
	import pin_select_pkg::*;
(
	// Clock and reset
	input  wire logic                      mclk_i,
	input  wire logic                      rst_i,
	// Decoded access
	input  wire logic [NUM_PINS-1:0]       wr_hit_i,
	input  wire logic [REG_W-1:0]          wdata_i,
	input  wire logic                      rd_i,
	input  wire logic [NUM_PINS-1:0]       rd_hit_i,
	// Contents and read data
	output logic      [NUM_PINS*REG_W-1:0] cfg_o,
	output logic      [REG_W-1:0]          rdata_o
);

	logic [REG_W-1:0] rd_mux;

	// --------------------------------------------------------------
	// Storage
	// --------------------------------------------------------------
	// All eight bits are kept, reserved ones included, so software
	// reads back exactly what it wrote.
	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++) begin : g_reg
			always_ff @(posedge mclk_i or posedge rst_i) begin
				if (rst_i) begin
					cfg_o[g*REG_W +: REG_W] <= PIN_REG_RESET; // R1
				end else if (wr_hit_i[g]) begin
					cfg_o[g*REG_W +: REG_W] <= wdata_i; // R12
				end
			end
		end
	endgenerate

	// --------------------------------------------------------------
	// Read path
	// --------------------------------------------------------------
	always_comb begin
		rd_mux = RDATA_UNMAPPED;
		for (int i = 0; i < NUM_PINS; i++) begin
			if (rd_hit_i[i]) begin
				rd_mux = cfg_o[i*REG_W +: REG_W];
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= RDATA_UNMAPPED;
		end else if (rd_i) begin
			rdata_o <= rd_mux;
		end
	end

endmodule

// [verilog/pin_function_cell.sv]
// One pin's function multiplexer with registered pad controls.
// Assumes the selector and sources are synchronous to mclk_i.
`timescale 1ns/1ps
module pin_function_cell
	import pin_select_pkg::*;
#(
	parameter int ALT_17_SRC = SRC_P1_WCLK
) (
	// Clock and reset
	input  wire logic                 mclk_i,
	input  wire logic                 rst_i,
	// Configuration
	input  wire logic [4:0]           sel_i,
	input  wire logic                 level_i,
	input  wire logic                 bitbang_i,
	// Sources and pad input
	input  wire logic [SRC_COUNT-1:0] src_i,
	input  wire logic                 pad_i,
	// Pad controls
	output logic                      pad_o,
	output logic                      pad_oe_o,
	output logic                      pad_ie_o,
	output logic                      fwd_o
);

	logic drv;
	logic oe;
	logic ie;

	// --------------------------------------------------------------
	// Function selection
	// --------------------------------------------------------------
	always_comb begin
		drv = 1'b0;
		oe  = 1'b1;
		ie  = 1'b0;
		case (pin_sel_type'(sel_i))
			SEL_INPUT: begin
				oe = 1'b0; // R2
				ie = 1'b1; // R2
			end
			SEL_LEVEL:    drv = level_i; // R3 R10
			SEL_BITBANG:  drv = bitbang_i; // R4
			SEL_PDM_CLK:  drv = src_i[SRC_PDM_CLK]; // R5
			SEL_CLK_OUT:  drv = src_i[SRC_CLK_OUT]; // R6
			SEL_IRQ_ONE:  drv = src_i[SRC_IRQ_ONE]; // R7
			SEL_IRQ_TWO:  drv = src_i[SRC_IRQ_TWO]; // R7
			SEL_IRQ_THR:  drv = src_i[SRC_IRQ_THR]; // R7
			SEL_IRQ_FOUR: drv = src_i[SRC_IRQ_FOUR]; // R7
			SEL_P1_WCLK:  drv = src_i[SRC_P1_WCLK]; // R8
			SEL_P1_BCLK:  drv = src_i[SRC_P1_BCLK]; // R8
			SEL_P1_DOUT:  drv = src_i[SRC_P1_DOUT]; // R9
			SEL_ALT_17:   drv = src_i[ALT_17_SRC];
			SEL_P2_BCLK:  drv = src_i[SRC_P2_BCLK]; // R9
			SEL_P2_DOUT:  drv = src_i[SRC_P2_DOUT]; // R9
			SEL_M_WCLK:   drv = src_i[SRC_M_WCLK]; // R9
			SEL_M_BCLK:   drv = src_i[SRC_M_BCLK]; // R9
			SEL_M_DOUT:   drv = src_i[SRC_M_DOUT]; // R9
			// Disabled and every reserved code: both buffers off.
			default: begin
				oe = 1'b0; // R1 R11
			end
		endcase
	end

	// --------------------------------------------------------------
	// Pad registers
	// --------------------------------------------------------------
	// The forwarded input is gated so a disabled pin reads as low
	// inside the device instead of following a floating pad.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pad_o    <= 1'b0;
			pad_oe_o <= 1'b0;
			pad_ie_o <= 1'b0;
			fwd_o    <= 1'b0;
		end else begin
			pad_o    <= drv;
			pad_oe_o <= oe;
			pad_ie_o <= ie;
			fwd_o    <= ie & pad_i; // R2
		end
	end

endmodule

// [verilog/pin_select_pkg.sv]
// Shared constants for the multifunction pin selection block.
// Assumes one 100 MHz clock and an 8-bit register port.
package pin_select_pkg;

	// --------------------------------------------------------------
	// Register map
	// --------------------------------------------------------------
	localparam int          REG_W          = 8;
	localparam int          ADDR_W         = 8;
	localparam int          NUM_PINS       = 3;
	localparam logic [7:0]  OFF_DATA_IN2   = 8'h44;
	localparam logic [7:0]  OFF_LINK_CLOCK = 8'h45;
	localparam logic [7:0]  OFF_LINK_DATA  = 8'h46;
	localparam logic [7:0]  PIN_REG_RESET  = 8'h00;
	localparam logic [7:0]  RDATA_UNMAPPED = 8'h00;

	// Pin indices inside the register and pin vectors.
	localparam int          PIN_DATA_IN2   = 0;
	localparam int          PIN_LINK_CLOCK = 1;
	localparam int          PIN_LINK_DATA  = 2;

	// --------------------------------------------------------------
	// Field layout of each pin register
	// --------------------------------------------------------------
	localparam int          SEL_LSB        = 0;
	localparam int          SEL_MSB        = 4;
	localparam int          LEVEL_BIT      = 6;

	// --------------------------------------------------------------
	// Function selector codes; any other code is reserved
	// --------------------------------------------------------------
	typedef enum logic [4:0] {
		SEL_DISABLED = 5'h00,
		SEL_INPUT    = 5'h01,
		SEL_LEVEL    = 5'h03,
		SEL_BITBANG  = 5'h04,
		SEL_PDM_CLK  = 5'h05,
		SEL_CLK_OUT  = 5'h06,
		SEL_IRQ_ONE  = 5'h07,
		SEL_IRQ_TWO  = 5'h08,
		SEL_IRQ_THR  = 5'h09,
		SEL_IRQ_FOUR = 5'h0a,
		SEL_P1_WCLK  = 5'h0c,
		SEL_P1_BCLK  = 5'h0d,
		SEL_P1_DOUT  = 5'h10,
		SEL_ALT_17   = 5'h11,
		SEL_P2_BCLK  = 5'h12,
		SEL_P2_DOUT  = 5'h15,
		SEL_M_WCLK   = 5'h1b,
		SEL_M_BCLK   = 5'h1c,
		SEL_M_DOUT   = 5'h1d
	} pin_sel_type;

	// --------------------------------------------------------------
	// Index of each internal output source in the source vector
	// --------------------------------------------------------------
	localparam int          SRC_PDM_CLK    = 0;
	localparam int          SRC_CLK_OUT    = 1;
	localparam int          SRC_IRQ_ONE    = 2;
	localparam int          SRC_IRQ_TWO    = 3;
	localparam int          SRC_IRQ_THR    = 4;
	localparam int          SRC_IRQ_FOUR   = 5;
	localparam int          SRC_P1_WCLK    = 6;
	localparam int          SRC_P1_BCLK    = 7;
	localparam int          SRC_P1_DOUT    = 8;
	localparam int          SRC_P2_BCLK    = 9;
	localparam int          SRC_P2_DOUT    = 10;
	localparam int          SRC_M_WCLK     = 11;
	localparam int          SRC_M_BCLK     = 12;
	localparam int          SRC_M_DOUT     = 13;
	localparam int          SRC_COUNT      = 14;

endpackage
